// File: sim/fcr_cmd_result_sva.sv
// port assertions for the command and result-status block
`timescale 1ns/1ps
module fcr_cmd_result_sva
(
   // clock and reset
   input wire logic I_CLK_SYS,
   input wire logic I_SYS_RST,
   // watched inputs
   input wire logic I_EXEC_DONE,
   input wire logic I_DATA_CRC_ERR,
   input wire logic I_NO_DATA_MARK,
   input wire logic I_SCAN_EQUAL,
   input wire logic I_WRITE_PROTECT,
   input wire logic I_DRIVE_READY,
   input wire logic I_TRACK_ZERO,
   // watched outputs
   input wire logic [7:0] O_DATA_OUT,
   input wire logic O_CMD_PHASE,
   input wire logic O_EXEC_PHASE,
   input wire logic O_RESULT_PHASE,
   input wire logic O_CMD_START,
   input wire fcr_pkg::fcr_cmd_t O_CMD_KIND,
   input wire logic O_SKIP,
   input wire logic [7:0] O_EXT_STATUS_TWO,
   input wire logic [7:0] O_DRIVE_STATUS
);
   import fcr_pkg::*;
   default clocking @(posedge I_CLK_SYS);
   endclocking
   default disable iff (I_SYS_RST);
   a_start_to_exec: assert property (O_CMD_START |-> O_EXEC_PHASE && !O_CMD_PHASE ##1 !O_CMD_START)
      else $error("command start without execution phase");
   a_done_to_result: assert property (O_EXEC_PHASE && I_EXEC_DONE |=> O_RESULT_PHASE && !O_EXEC_PHASE)
      else $error("no result phase after done");
   a_data_idle_zero: assert property (!O_RESULT_PHASE |-> O_DATA_OUT == 8'h00)
      else $error("data out not zero outside result phase");
   a_pins_follow: assert property (!$past(I_SYS_RST) |-> O_DRIVE_STATUS[6] == $past(I_WRITE_PROTECT)
      && O_DRIVE_STATUS[5] == $past(I_DRIVE_READY) && O_DRIVE_STATUS[4] == $past(I_TRACK_ZERO))
      else $error("drive status pins wrong");
   a_unused_zero: assert property (O_DRIVE_STATUS[7] == 1'b0 && O_DRIVE_STATUS[3] == 1'b0
      && O_EXT_STATUS_TWO[7] == 1'b0)
      else $error("unused status bit set");
   a_crc_sets: assert property (O_EXEC_PHASE && I_DATA_CRC_ERR |-> ##[1:2] O_EXT_STATUS_TWO[5])
      else $error("data crc bit not set");
   a_no_mark_sets: assert property (O_EXEC_PHASE && I_NO_DATA_MARK |-> ##[1:2] O_EXT_STATUS_TWO[0])
      else $error("missing data mark bit not set");
   a_scan_eq_sets: assert property (O_EXEC_PHASE && I_SCAN_EQUAL && O_CMD_KIND == CMD_SCAN
      |-> ##[1:2] O_EXT_STATUS_TWO[3])
      else $error("scan equal bit not set");
   a_bad_needs_wrong: assert property (O_EXT_STATUS_TWO[1] |-> O_EXT_STATUS_TWO[4])
      else $error("bad track without wrong track");
   a_write_no_skip: assert property ($rose(O_EXEC_PHASE) && (O_CMD_KIND == CMD_WRITE
      || O_CMD_KIND == CMD_WRITE_DEL || O_CMD_KIND == CMD_READ_ID) |-> !O_SKIP)
      else $error("skip flag set for a command without skip");
endmodule
bind fcr_cmd_result fcr_cmd_result_sva chk (.I_CLK_SYS(I_CLK_SYS), .I_SYS_RST(I_SYS_RST),
   .I_EXEC_DONE(I_EXEC_DONE), .I_DATA_CRC_ERR(I_DATA_CRC_ERR), .I_NO_DATA_MARK(I_NO_DATA_MARK),
   .I_SCAN_EQUAL(I_SCAN_EQUAL), .I_WRITE_PROTECT(I_WRITE_PROTECT), .I_DRIVE_READY(I_DRIVE_READY),
   .I_TRACK_ZERO(I_TRACK_ZERO), .O_DATA_OUT(O_DATA_OUT), .O_CMD_PHASE(O_CMD_PHASE),
   .O_EXEC_PHASE(O_EXEC_PHASE), .O_RESULT_PHASE(O_RESULT_PHASE), .O_CMD_START(O_CMD_START),
   .O_CMD_KIND(O_CMD_KIND), .O_SKIP(O_SKIP), .O_EXT_STATUS_TWO(O_EXT_STATUS_TWO),
   .O_DRIVE_STATUS(O_DRIVE_STATUS));

// File: sim/fcr_host_model.sv
// host side model: writes command bytes, reads result bytes
`timescale 1ns/1ps
module fcr_host_model
(
   // clock
   input wire logic i_clk,
   // data register strobes
   output logic o_wr,
   output logic [7:0] o_din,
   output logic o_rd
);
   initial
   begin
      o_wr = 1'b0;
      o_din = 8'h00;
      o_rd = 1'b0;
   end
   // bytes back to back, strobe held between them
   task automatic send(input logic [7:0] b[9], input int n);
      for (int i = 0; i < n; i++)
      begin
         @(negedge i_clk);
         o_wr = 1'b1;
         o_din = b[i];
      end
      @(negedge i_clk);
      o_wr = 1'b0;
      o_din = ~o_din; // released bus must not show a stale byte
   endtask
   // results taken one per cycle in the result phase only
   task automatic drain(input int n);
      for (int i = 0; i < n; i++)
      begin
         @(negedge i_clk);
         o_rd = 1'b1;
      end
      @(negedge i_clk);
      o_rd = 1'b0;
   endtask
endmodule

// File: sim/tb_floppy_command_result_status.sv
// self-checking bench for the command and result-status block
`timescale 1ns/1ps
module tb_floppy_command_result_status;
   import fcr_pkg::*;
   logic clk, rst, wr, rd, done, mark, del, dcrc, sid, nf, sceq, scnot, nodm, abrt, wp, rdy, t0, icrc, noid;
   logic execp, resp, mt, dens, skip, seek, head;
   logic [1:0] drive;
   logic [7:0] din, dout, idtrk, trk, st2, st3, track, dlen, rtrk, rhd, rsec, rsz, hnum, sec, sz, eot, gap;
   logic [2:0] prev_hd;
   fcr_cmd_t kind;
   int err_count, samples_checked, seed;
   logic [7:0] exp_q[$];
   fcr_host_model host (.i_clk(clk), .o_wr(wr), .o_din(din), .o_rd(rd));
   fcr_cmd_result uut (.I_CLK_SYS(clk), .I_SYS_RST(rst), .I_DATA_WR(wr), .I_DATA_IN(din), .I_DATA_RD(rd),
      .O_DATA_OUT(dout), .O_CMD_PHASE(), .O_EXEC_PHASE(execp), .O_RESULT_PHASE(resp), .O_CMD_START(),
      .O_CMD_KIND(kind), .O_MULTI_TRACK(mt), .O_DENSITY(dens), .O_SKIP(skip), .O_IMPLIED_SEEK(seek),
      .O_HEAD(head), .O_DRIVE(drive), .O_TRACK(track), .O_HEAD_NUM(hnum), .O_SECTOR(sec), .O_SIZE_CODE(sz),
      .O_END_SECTOR(eot), .O_GAP_LEN(gap), .O_DATA_LEN(dlen), .I_EXEC_DONE(done), .I_DATA_MARK(mark),
      .I_MARK_DELETED(del), .I_DATA_CRC_ERR(dcrc), .I_ID_CRC_ERR(icrc), .I_ID_SEEN(sid), .I_ID_TRACK(idtrk),
      .I_TRACK_REG(trk), .I_SECTOR_NOT_FOUND(nf), .I_SCAN_EQUAL(sceq), .I_SCAN_NOT_MET(scnot),
      .I_NO_DATA_MARK(nodm), .I_NO_ID_MARK(noid), .I_END_OF_TRACK(1'b0), .I_OVERRUN(1'b0),
      .I_NOT_WRITABLE(1'b0), .I_ABORT(abrt), .I_RES_TRACK(rtrk), .I_RES_HEAD(rhd), .I_RES_SECTOR(rsec),
      .I_RES_SIZE(rsz), .I_WRITE_PROTECT(wp), .I_DRIVE_READY(rdy), .I_TRACK_ZERO(t0),
      .O_EXT_STATUS_TWO(st2), .O_DRIVE_STATUS(st3));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // result bytes compared as they are consumed
   always @(posedge clk)
      if (resp === 1'b1 && rd === 1'b1 && exp_q.size() > 0)
         check(dout, exp_q.pop_front());
   // ev: abort, nodm, scan not, scan eq, id seen, not found, crc, deleted, mark
   task automatic run(input logic [4:0] low, input logic [2:0] fm, input fcr_cmd_t k, input logic [8:0] ev,
      input logic [7:0] id);
      logic [7:0] cmd[9];
      logic [7:0] s1, s2;
      logic c, wg, ic, ni;
      int n;
      cmd[0] = {3'($random(seed)) & fm, low};
      cmd[1] = {1'($random(seed)), 4'h0, 3'($random(seed))};
      for (int i = 2; i < 9; i++)
         cmd[i] = 8'($random(seed));
      n = (k == CMD_READ_ID) ? 2 : 9;
      {wp, rdy, t0} = 3'($random(seed));
      {rtrk, rhd, rsec, rsz} = 32'($random(seed));
      host.send(cmd, n);
      for (int w = 0; w < 8 && execp !== 1'b1; w++)
         @(negedge clk);
      // drive status lags the second command byte by one clock
      @(negedge clk);
      check({5'h0, kind}, {5'h0, k});
      check({mt, dens, skip, seek, head, 1'b0, drive}, {cmd[0][7:5] & {2'b11, k != CMD_WRITE && k != CMD_WRITE_DEL},
         cmd[1][7], cmd[1][2], 1'b0, cmd[1][1:0]});
      check(track, n == 2 ? 8'h00 : cmd[2]);
      check(hnum, n == 2 ? 8'h00 : cmd[3]);
      check(sec, n == 2 ? 8'h00 : cmd[4]);
      check(sz, n == 2 ? 8'h00 : cmd[5]);
      check(eot, n == 2 ? 8'h00 : cmd[6]);
      check(gap, n == 2 ? 8'h00 : cmd[7]);
      check(dlen, n == 2 ? 8'h00 : cmd[8]);
      check(st3, {1'b0, wp, rdy, t0, 1'b0, cmd[1][2:0]});
      prev_hd = cmd[1][2:0];
      idtrk = id;
      {abrt, nodm, scnot, sceq, sid, nf, dcrc, del, mark} = ev;
      {ic, ni} = 2'($random(seed));
      {icrc, noid} = {ic, ni};
      @(negedge clk);
      {abrt, nodm, scnot, sceq, sid, nf, dcrc, del, mark} = 9'h000;
      {icrc, noid} = 2'b00;
      done = 1'b1;
      @(negedge clk);
      done = 1'b0;
      idtrk = ~id;
      c = (k == CMD_READ_DEL) ? ev[0] & ~ev[1] : (k == CMD_READ || k == CMD_SCAN) && ev[0] && ev[1];
      wg = ev[3] & ev[4] & (id != trk);
      s2 = {1'b0, c, ev[2], wg, ev[5] && k == CMD_SCAN, ev[6] && k == CMD_SCAN, wg && id == 8'hFF, ev[7]};
      s1 = {2'b00, ev[2] | ic, 2'b00, ev[3], 1'b0, ev[7] | ni};
      exp_q.push_back({(ev[8] | c | wg | (|s1)) ? IC_ABNORMAL : IC_NORMAL, 3'b000, cmd[1][2:0]});
      exp_q.push_back(s1);
      exp_q.push_back(s2);
      exp_q.push_back(rtrk);
      exp_q.push_back(rhd);
      exp_q.push_back(rsec);
      exp_q.push_back(rsz);
      for (int w = 0; w < 8 && resp !== 1'b1; w++)
         @(negedge clk);
      check(st2, s2);
      host.drain(7);
      check({7'h00, resp}, 8'h00);
   endtask
   // an unknown opcode answers at once with a single status byte
   task automatic run_bad();
      logic [7:0] cmd[9];
      for (int i = 0; i < 9; i++)
         cmd[i] = 8'($random(seed));
      cmd[0][4:0] = 5'h1F;
      host.send(cmd, 1);
      check({5'h0, kind}, {5'h0, CMD_INVALID});
      check({7'h00, resp}, 8'h01);
      exp_q.push_back({IC_INVALID, 3'b000, prev_hd});
      host.drain(1);
      check({7'h00, resp}, 8'h00);
   endtask
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // a full run needs under 2000 cycles
   initial
   begin
      #100000;
      err_count++;
      conclude();
   end
   initial
   begin
      seed = 32'hd1f2;
      rst = 1'b1;
      done = 1'b0;
      {abrt, nodm, scnot, sceq, sid, nf, dcrc, del, mark} = 9'h000;
      {icrc, noid} = 2'b00;
      prev_hd = 3'h0;
      {wp, rdy, t0} = 3'h0;
      {idtrk, rtrk, rhd, rsec, rsz} = 40'h0;
      trk = 8'($random(seed)) & 8'h7F;
      repeat (12) @(negedge clk);
      rst = 1'b0;
      for (int r = 0; r < 2; r++)
      begin
         run_bad();
         run(OP_READ, 3'h7, CMD_READ, 9'h003, trk);
         run(OP_READ, 3'h7, CMD_READ, 9'h063, trk);
         run(OP_READ_DEL, 3'h7, CMD_READ_DEL, 9'h001, trk);
         run(OP_READ_DEL, 3'h7, CMD_READ_DEL, 9'h003, trk);
         run(OP_WRITE, 3'h7, CMD_WRITE, 9'h004, trk);
         run(OP_WRITE_DEL, 3'h7, CMD_WRITE_DEL, 9'h018, 8'hFF);
         run(OP_READ, 3'h7, CMD_READ, 9'h018, trk ^ 8'h01);
         run(OP_READ, 3'h7, CMD_READ, 9'h008, trk ^ 8'h01);
         run(OP_READ_TRACK, 3'h3, CMD_READ_TRACK, 9'h018, trk);
         run(OP_READ_ID, 3'h2, CMD_READ_ID, 9'h080, trk);
         run(OP_SCAN_EQ, 3'h7, CMD_SCAN, 9'h063, trk);
         run(OP_SCAN_LE, 3'h7, CMD_SCAN, 9'h040, trk);
         run(OP_SCAN_HE, 3'h7, CMD_SCAN, 9'h120, trk);
      end
      conclude();
   end
endmodule

// File: verilog/fcr_cmd_decode.sv
// opcode byte decoder: command kind, length and flags
`timescale 1ns/1ps
module fcr_cmd_decode
(
   // opcode byte
   input wire logic [7:0] i_opcode,
   // decoded
   output fcr_pkg::fcr_cmd_t o_kind,
   output logic [3:0] o_len,
   output logic o_multi_track,
   output logic o_density,
   output logic o_skip
);
   import fcr_pkg::*;

   logic [4:0] low;
   logic is_read, is_write, is_wdel, is_rdel, is_track, is_id, is_scan;

   assign low = i_opcode[4:0];
   assign is_read = (low == OP_READ);
   assign is_write = (low == OP_WRITE);
   assign is_wdel = (low == OP_WRITE_DEL);
   assign is_rdel = (low == OP_READ_DEL);
   // fixed-zero top bits are checked so stray opcodes come back invalid
   assign is_track = (low == OP_READ_TRACK) & ~i_opcode[MT_BIT];
   assign is_id = (low == OP_READ_ID) & ~i_opcode[MT_BIT] & ~i_opcode[SKIP_BIT];
   assign is_scan = (low == OP_SCAN_EQ) | (low == OP_SCAN_LE) | (low == OP_SCAN_HE);

   assign o_kind = is_read ? CMD_READ :
                   is_write ? CMD_WRITE :
                   is_wdel ? CMD_WRITE_DEL :
                   is_rdel ? CMD_READ_DEL :
                   is_track ? CMD_READ_TRACK :
                   is_id ? CMD_READ_ID :
                   is_scan ? CMD_SCAN : CMD_INVALID;
   assign o_len = is_id ? LEN_ID : LEN_XFER;
   assign o_multi_track = i_opcode[MT_BIT] & ~is_track & ~is_id;
   assign o_density = i_opcode[DENS_BIT];
   // writes carry no skip; forced low whatever the host sent
   assign o_skip = i_opcode[SKIP_BIT] & ~is_write & ~is_wdel & ~is_id;
endmodule

// File: verilog/fcr_cmd_result.sv
// top: command byte collection, event capture, result phase
`timescale 1ns/1ps
module fcr_cmd_result
(
   // clock and reset
   input wire logic I_CLK_SYS,
   input wire logic I_SYS_RST,
   // host data register
   input wire logic I_DATA_WR,
   input wire logic [7:0] I_DATA_IN,
   input wire logic I_DATA_RD,
   output logic [7:0] O_DATA_OUT,
   output logic O_CMD_PHASE,
   output logic O_EXEC_PHASE,
   output logic O_RESULT_PHASE,
   // decoded command to the execution engine
   output logic O_CMD_START,
   output fcr_pkg::fcr_cmd_t O_CMD_KIND,
   output logic O_MULTI_TRACK,
   output logic O_DENSITY,
   output logic O_SKIP,
   output logic O_IMPLIED_SEEK,
   output logic O_HEAD,
   output logic [1:0] O_DRIVE,
   output logic [7:0] O_TRACK,
   output logic [7:0] O_HEAD_NUM,
   output logic [7:0] O_SECTOR,
   output logic [7:0] O_SIZE_CODE,
   output logic [7:0] O_END_SECTOR,
   output logic [7:0] O_GAP_LEN,
   output logic [7:0] O_DATA_LEN,
   // execution events
   input wire logic I_EXEC_DONE,
   input wire logic I_DATA_MARK,
   input wire logic I_MARK_DELETED,
   input wire logic I_DATA_CRC_ERR,
   input wire logic I_ID_CRC_ERR,
   input wire logic I_ID_SEEN,
   input wire logic [7:0] I_ID_TRACK,
   input wire logic [7:0] I_TRACK_REG,
   input wire logic I_SECTOR_NOT_FOUND,
   input wire logic I_SCAN_EQUAL,
   input wire logic I_SCAN_NOT_MET,
   input wire logic I_NO_DATA_MARK,
   input wire logic I_NO_ID_MARK,
   input wire logic I_END_OF_TRACK,
   input wire logic I_OVERRUN,
   input wire logic I_NOT_WRITABLE,
   input wire logic I_ABORT,
   // final position for the result bytes
   input wire logic [7:0] I_RES_TRACK,
   input wire logic [7:0] I_RES_HEAD,
   input wire logic [7:0] I_RES_SECTOR,
   input wire logic [7:0] I_RES_SIZE,
   // drive pins
   input wire logic I_WRITE_PROTECT,
   input wire logic I_DRIVE_READY,
   input wire logic I_TRACK_ZERO,
   // status views
   output logic [7:0] O_EXT_STATUS_TWO,
   output logic [7:0] O_DRIVE_STATUS
);
   import fcr_pkg::*;

   fcr_phase_t phase;
   fcr_phase_t next_phase;
   fcr_cmd_t cmd_kind;
   fcr_cmd_t dec_kind;
   logic [7:0] cmd_byte [0:CMD_MAX-1];
   logic [7:0] res_byte [0:RES_LEN-1];
   logic [3:0] cmd_idx;
   logic [3:0] cmd_len;
   logic [3:0] dec_len;
   logic [2:0] res_idx;
   logic [2:0] res_last;
   logic dec_mt, dec_dens, dec_skip;
   logic mt, dens, skip;
   logic [FLAG_N-1:0] flags;
   logic [FLAG_N-1:0] next_flags;
   logic [FLAG_N-1:0] flag_set;
   logic [7:0] st0, st1, st2, st3;
   logic [7:0] data_out;
   logic [7:0] ext_two;
   logic [7:0] drv_status;
   logic start_pulse;

   logic in_idle, in_cmd, in_exec, in_result;
   logic first_wr, start_valid, start_invalid, last_byte;
   logic exec_done, res_take, res_end, flag_clear;
   logic mark_normal_cmd, mark_bad, trk_diff;

   assign in_idle = (phase == PH_IDLE);
   assign in_cmd = (phase == PH_CMD);
   assign in_exec = (phase == PH_EXEC);
   assign in_result = (phase == PH_RESULT);
   assign first_wr = in_idle & I_DATA_WR;
   assign start_valid = first_wr & (dec_kind != CMD_INVALID);
   assign start_invalid = first_wr & (dec_kind == CMD_INVALID);
   assign last_byte = in_cmd & I_DATA_WR & (cmd_idx == cmd_len - 4'h1);
   assign exec_done = in_exec & I_EXEC_DONE;
   // reads outside the result phase are ignored
   assign res_take = in_result & I_DATA_RD;
   assign res_end = res_take & (res_idx == res_last);
   assign flag_clear = last_byte | start_invalid;

   fcr_cmd_decode u_decode
   (
      .i_opcode(I_DATA_IN),
      .o_kind(dec_kind),
      .o_len(dec_len),
      .o_multi_track(dec_mt),
      .o_density(dec_dens),
      .o_skip(dec_skip)
   );

   // event capture, only while a command executes
   assign mark_normal_cmd = (cmd_kind == CMD_READ) | (cmd_kind == CMD_SCAN);
   assign mark_bad = (cmd_kind == CMD_READ_DEL) ? ~I_MARK_DELETED : (mark_normal_cmd & I_MARK_DELETED);
   assign trk_diff = I_ID_SEEN & (I_ID_TRACK != I_TRACK_REG);
   assign flag_set[F_CTRL_MARK] = in_exec & I_DATA_MARK & mark_bad;
   assign flag_set[F_DATA_CRC] = in_exec & I_DATA_CRC_ERR;
   assign flag_set[F_ID_CRC] = in_exec & I_ID_CRC_ERR;
   assign flag_set[F_NOT_FOUND] = in_exec & I_SECTOR_NOT_FOUND;
   assign flag_set[F_TRK_DIFF] = in_exec & trk_diff;
   assign flag_set[F_TRK_FF] = in_exec & trk_diff & (I_ID_TRACK == BAD_TRACK_ID);
   assign flag_set[F_SCAN_EQ] = in_exec & (cmd_kind == CMD_SCAN) & I_SCAN_EQUAL;
   assign flag_set[F_SCAN_NOT] = in_exec & (cmd_kind == CMD_SCAN) & I_SCAN_NOT_MET;
   assign flag_set[F_NO_DMARK] = in_exec & I_NO_DATA_MARK;
   assign flag_set[F_NO_IDMARK] = in_exec & I_NO_ID_MARK;
   assign flag_set[F_EOT] = in_exec & I_END_OF_TRACK;
   assign flag_set[F_OVERRUN] = in_exec & I_OVERRUN;
   assign flag_set[F_NOT_WRITABLE] = in_exec & I_NOT_WRITABLE;
   assign flag_set[F_ABORT] = in_exec & I_ABORT;
   // set beats clear, but an event on the clearing edge is lost: capture runs only in the execution phase
   assign next_flags = (flag_clear ? {FLAG_N{1'b0}} : flags) | flag_set;

   // encoder sees next_flags so an event on the done edge still counts
   fcr_status_encode u_status
   (
      .i_flags(next_flags),
      .i_invalid(start_invalid),
      .i_head(cmd_byte[1][HEAD_BIT]),
      .i_drive(cmd_byte[1][1:0]),
      .i_write_protect(I_WRITE_PROTECT),
      .i_ready(I_DRIVE_READY),
      .i_track_zero(I_TRACK_ZERO),
      .o_st0(st0),
      .o_st1(st1),
      .o_st2(st2),
      .o_st3(st3)
   );

   always_comb
   begin
      next_phase = phase;
      unique case (phase)
         PH_IDLE:
         begin
            if (start_valid)
               next_phase = PH_CMD;
            else if (start_invalid)
               next_phase = PH_RESULT;
         end
         PH_CMD:
         begin
            if (last_byte)
               next_phase = PH_EXEC;
         end
         PH_EXEC:
         begin
            if (I_EXEC_DONE)
               next_phase = PH_RESULT;
         end
         PH_RESULT:
         begin
            if (res_end)
               next_phase = PH_IDLE;
         end
      endcase
   end

   always_ff @(posedge I_CLK_SYS)
   begin
      if (I_SYS_RST)
         phase <= PH_IDLE;
      else
         phase <= next_phase;
   end

   // opcode flags and command length latch on the first byte
   always_ff @(posedge I_CLK_SYS)
   begin
      if (I_SYS_RST)
      begin
         cmd_kind <= CMD_INVALID;
         cmd_len <= LEN_XFER;
         mt <= 1'b0;
         dens <= 1'b0;
         skip <= 1'b0;
      end
      else if (first_wr)
      begin
         cmd_kind <= dec_kind;
         cmd_len <= dec_len;
         mt <= dec_mt;
         dens <= dec_dens;
         skip <= dec_skip;
      end
   end

   // command bytes; stale bytes are wiped so a short command shows zeros
   always_ff @(posedge I_CLK_SYS)
   begin
      if (I_SYS_RST)
      begin
         cmd_idx <= 4'h0;
         for (int i = 0; i < CMD_MAX; i++)
            cmd_byte[i] <= 8'h00;
      end
      else if (first_wr)
      begin
         cmd_idx <= 4'h1;
         for (int i = 0; i < CMD_MAX; i++)
            cmd_byte[i] <= (i == 0) ? I_DATA_IN : 8'h00;
      end
      else if (in_cmd & I_DATA_WR)
      begin
         cmd_idx <= cmd_idx + 4'h1;
         cmd_byte[cmd_idx] <= I_DATA_IN;
      end
   end

   always_ff @(posedge I_CLK_SYS)
   begin
      if (I_SYS_RST)
         flags <= {FLAG_N{1'b0}};
      else
         flags <= next_flags;
   end

   always_ff @(posedge I_CLK_SYS)
   begin
      if (I_SYS_RST)
         start_pulse <= 1'b0;
      else
         start_pulse <= last_byte;
   end

   // result bytes captured once; the host then walks them in order
   always_ff @(posedge I_CLK_SYS)
   begin
      if (I_SYS_RST)
      begin
         res_last <= RES_LAST_FULL;
         for (int i = 0; i < RES_LEN; i++)
            res_byte[i] <= 8'h00;
      end
      else if (exec_done)
      begin
         res_last <= RES_LAST_FULL;
         res_byte[0] <= st0;
         res_byte[1] <= st1;
         res_byte[2] <= st2;
         res_byte[3] <= I_RES_TRACK;
         res_byte[4] <= I_RES_HEAD;
         res_byte[5] <= I_RES_SECTOR;
         res_byte[6] <= I_RES_SIZE;
      end
      else if (start_invalid)
      begin
         res_last <= RES_LAST_INVALID;
         res_byte[0] <= st0;
      end
   end

   always_ff @(posedge I_CLK_SYS)
   begin
      if (I_SYS_RST)
      begin
         res_idx <= 3'h0;
         data_out <= 8'h00;
      end
      else if (exec_done | start_invalid)
      begin
         res_idx <= 3'h0;
         data_out <= st0;
      end
      else if (res_take)
      begin
         res_idx <= res_end ? 3'h0 : res_idx + 3'h1;
         data_out <= res_end ? 8'h00 : res_byte[res_idx + 3'h1];
      end
   end

   // live status views, one clock behind their sources
   always_ff @(posedge I_CLK_SYS)
   begin
      if (I_SYS_RST)
      begin
         ext_two <= 8'h00;
         drv_status <= 8'h00;
      end
      else
      begin
         ext_two <= st2;
         drv_status <= st3;
      end
   end

   assign O_DATA_OUT = data_out;
   assign O_CMD_PHASE = in_cmd;
   assign O_EXEC_PHASE = in_exec;
   assign O_RESULT_PHASE = in_result;
   assign O_CMD_START = start_pulse;
   assign O_CMD_KIND = cmd_kind;
   assign O_MULTI_TRACK = mt;
   assign O_DENSITY = dens;
   assign O_SKIP = skip;
   assign O_IMPLIED_SEEK = cmd_byte[1][SEEK_BIT];
   assign O_HEAD = cmd_byte[1][HEAD_BIT];
   assign O_DRIVE = cmd_byte[1][1:0];
   assign O_TRACK = cmd_byte[2];
   assign O_HEAD_NUM = cmd_byte[3];
   assign O_SECTOR = cmd_byte[4];
   assign O_SIZE_CODE = cmd_byte[5];
   assign O_END_SECTOR = cmd_byte[6];
   assign O_GAP_LEN = cmd_byte[7];
   assign O_DATA_LEN = cmd_byte[8];
   assign O_EXT_STATUS_TWO = ext_two;
   assign O_DRIVE_STATUS = drv_status;
endmodule

// File: verilog/fcr_pkg.sv
// constants and types for the floppy command and result-status block
package fcr_pkg;
   typedef enum logic [2:0] {CMD_READ, CMD_WRITE, CMD_WRITE_DEL, CMD_READ_DEL, CMD_READ_TRACK, CMD_READ_ID,
      CMD_SCAN, CMD_INVALID} fcr_cmd_t;
   typedef enum logic [1:0] {PH_IDLE, PH_CMD, PH_EXEC, PH_RESULT} fcr_phase_t;
   // opcode low five bits
   localparam logic [4:0] OP_READ = 5'h06;
   localparam logic [4:0] OP_WRITE = 5'h05;
   localparam logic [4:0] OP_WRITE_DEL = 5'h09;
   localparam logic [4:0] OP_READ_DEL = 5'h0C;
   localparam logic [4:0] OP_READ_TRACK = 5'h02;
   localparam logic [4:0] OP_READ_ID = 5'h0A;
   localparam logic [4:0] OP_SCAN_EQ = 5'h11;
   localparam logic [4:0] OP_SCAN_LE = 5'h19;
   localparam logic [4:0] OP_SCAN_HE = 5'h1D;
   // command byte fields
   localparam int MT_BIT = 7;
   localparam int DENS_BIT = 6;
   localparam int SKIP_BIT = 5;
   localparam int SEEK_BIT = 7;
   localparam int HEAD_BIT = 2;
   localparam logic [3:0] LEN_XFER = 4'h9;
   localparam logic [3:0] LEN_ID = 4'h2;
   localparam int CMD_MAX = 9;
   localparam int RES_LEN = 7;
   localparam logic [2:0] RES_LAST_FULL = 3'h6;
   localparam logic [2:0] RES_LAST_INVALID = 3'h0;
   localparam logic [7:0] BAD_TRACK_ID = 8'hFF;
   // interrupt codes of the first status byte
   localparam logic [1:0] IC_NORMAL = 2'h0;
   localparam logic [1:0] IC_ABNORMAL = 2'h1;
   localparam logic [1:0] IC_INVALID = 2'h2;
   // sticky event flags
   localparam int F_CTRL_MARK = 0;
   localparam int F_DATA_CRC = 1;
   localparam int F_ID_CRC = 2;
   localparam int F_NOT_FOUND = 3;
   localparam int F_TRK_DIFF = 4;
   localparam int F_TRK_FF = 5;
   localparam int F_SCAN_EQ = 6;
   localparam int F_SCAN_NOT = 7;
   localparam int F_NO_DMARK = 8;
   localparam int F_NO_IDMARK = 9;
   localparam int F_EOT = 10;
   localparam int F_OVERRUN = 11;
   localparam int F_NOT_WRITABLE = 12;
   localparam int F_ABORT = 13;
   localparam int FLAG_N = 14;
endpackage

// File: verilog/fcr_status_encode.sv
// builds the four status bytes from sticky flags and drive pins
`timescale 1ns/1ps
module fcr_status_encode
(
   // sources
   input wire logic [fcr_pkg::FLAG_N-1:0] i_flags,
   input wire logic i_invalid,
   input wire logic i_head,
   input wire logic [1:0] i_drive,
   input wire logic i_write_protect,
   input wire logic i_ready,
   input wire logic i_track_zero,
   // status bytes
   output logic [7:0] o_st0,
   output logic [7:0] o_st1,
   output logic [7:0] o_st2,
   output logic [7:0] o_st3
);
   import fcr_pkg::*;

   logic abnormal;
   logic [1:0] code;
   logic wrong_track, bad_track;

   assign wrong_track = i_flags[F_NOT_FOUND] & i_flags[F_TRK_DIFF];
   assign bad_track = i_flags[F_NOT_FOUND] & i_flags[F_TRK_FF];

   assign o_st1 = {i_flags[F_EOT], 1'b0,
                   i_flags[F_DATA_CRC] | i_flags[F_ID_CRC],
                   i_flags[F_OVERRUN], 1'b0, i_flags[F_NOT_FOUND], i_flags[F_NOT_WRITABLE],
                   i_flags[F_NO_DMARK] | i_flags[F_NO_IDMARK]};
   assign o_st2 = {1'b0,
                   i_flags[F_CTRL_MARK],
                   i_flags[F_DATA_CRC],
                   wrong_track,
                   i_flags[F_SCAN_EQ],
                   i_flags[F_SCAN_NOT],
                   bad_track,
                   i_flags[F_NO_DMARK]};
   assign o_st3 = {1'b0, i_write_protect, i_ready, i_track_zero,
                   1'b0, i_head, i_drive};

   // scan outcomes are informational, not a failed command
   assign abnormal = i_flags[F_ABORT] | (|o_st1) | i_flags[F_CTRL_MARK] | wrong_track | bad_track;
   assign code = i_invalid ? IC_INVALID : (abnormal ? IC_ABNORMAL : IC_NORMAL);
   assign o_st0 = {code, 3'h0, i_head, i_drive};
endmodule
